// ### rtl/pmrc_ctrl.sv
// power mode, reset source and code protection control
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_defs.svh"

module pmrc_ctrl (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_reset,
	input  wire logic                   i_clk_en,
	// register port
	input  wire logic [7:0]             i_addr,
	input  wire logic [31:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic [31:0]                 o_rdata,
	// core side
	input  wire logic                   i_sleep_req,
	input  wire pmrc_pkg::pmrc_mode_t   i_sleep_mode,
	input  wire pmrc_pkg::pmrc_wake_t   i_wake,
	// pins and analog sources
	input  wire logic                   i_reset_n_pin,
	input  wire logic                   i_wake_pin,
	input  wire logic                   i_wdt_reset,
	input  wire logic                   i_por,
	input  wire logic                   i_bod_irq_lvl,
	input  wire logic                   i_bod_rst_lvl,
	input  wire logic [31:0]            i_crp_word,
	// outputs
	output pmrc_pkg::pmrc_mode_t        o_mode,
	output pmrc_pkg::pmrc_gate_t        o_gate,
	output pmrc_pkg::pmrc_access_t      o_access,
	output pmrc_pkg::pmrc_crp_t         o_crp_level,
	output logic                        o_chip_reset,
	output logic                        o_bod_irq,
	output logic [31:0]                 o_boot_addr
);

	// chip reset is held this many cycles after the last source drops
	localparam int RST_STRETCH = 4;

	// ----------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------
	logic [2:0] rst_pin_q;  // [0] is read only by [1]
	logic [2:0] wake_pin_q;
	logic       rst_pin_lvl_q;
	logic       wake_lvl_q;

	// three stages; level changes once stages two and three agree
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rst_pin_q     <= 3'h7;
			wake_pin_q    <= 3'h7;
			rst_pin_lvl_q <= 1'b1;
			wake_lvl_q    <= 1'b1;
		end else if (i_clk_en) begin
			rst_pin_q  <= {rst_pin_q[1:0], i_reset_n_pin};
			wake_pin_q <= {wake_pin_q[1:0], i_wake_pin};
			if (rst_pin_q[1] == rst_pin_q[2]) begin
				rst_pin_lvl_q <= rst_pin_q[2];
			end
			if (wake_pin_q[1] == wake_pin_q[2]) begin
				wake_lvl_q <= wake_pin_q[2];
			end
		end
	end

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	logic [4:0] ctrl_q;     // lock, wdo keep, bod keep, wdt on irc, isp pin off
	logic [3:0] bod_q;      // [1:0] irq level select, [3:2] reset level select
	logic       bod_flag_q; // sticky brownout status

	wire wr_ctrl = i_wr && (i_addr == `PMRC_CTRL_OFS);
	wire wr_stat = i_wr && (i_addr == `PMRC_STAT_OFS);
	wire wr_bod  = i_wr && (i_addr == `PMRC_BOD_OFS);
	wire dp_lock = ctrl_q[`PMRC_CTRL_LOCK_BIT];

	// ----------------------------------------------------------
	// reset sources
	// ----------------------------------------------------------
	// a 50 ns pulse is ten cycles, longer than the filter delay, so it lands
	wire pin_rst = !rst_pin_lvl_q;
	wire any_rst = pin_rst || i_wdt_reset || i_por || i_bod_rst_lvl;
	logic [2:0] rst_cnt_q;  // stretch so the flash controller sees a clean reset

	// stretched chip reset
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rst_cnt_q <= 3'(RST_STRETCH);
		end else if (i_clk_en) begin
			if (any_rst) begin
				rst_cnt_q <= 3'(RST_STRETCH);
			end else if (rst_cnt_q != 3'h0) begin
				rst_cnt_q <= rst_cnt_q - 3'h1;
			end
		end
	end
	wire chip_rst = any_rst || (rst_cnt_q != 3'h0);

	// ----------------------------------------------------------
	// register writes
	// ----------------------------------------------------------
	// chip reset returns registers to defaults
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ctrl_q     <= `PMRC_CTRL_RST;
			bod_q      <= `PMRC_BOD_RST;
			bod_flag_q <= 1'b0;
		end else if (i_clk_en) begin
			if (chip_rst) begin
				ctrl_q     <= `PMRC_CTRL_RST;
				bod_q      <= `PMRC_BOD_RST;
				bod_flag_q <= 1'b0;
			end else begin
				if (wr_ctrl) begin
					ctrl_q <= i_wdata[4:0];
				end
				if (wr_bod) begin
					bod_q <= i_wdata[3:0];
				end
				// set wins over write-one clear
				if (i_bod_irq_lvl) begin
					bod_flag_q <= 1'b1;
				end else if (wr_stat && i_wdata[0]) begin
					bod_flag_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------
	// power mode machine
	// ----------------------------------------------------------
	pmrc_pkg::pmrc_mode_t mode_q;
	pmrc_pkg::pmrc_mode_t mode_d;
	wire gpwake = i_wake.gpio || i_wake.wdt || i_wake.usb;

	// next mode
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			pmrc_pkg::PMRC_ACTIVE: begin
				if (i_sleep_req) begin
					if (i_sleep_mode == pmrc_pkg::PMRC_DPDOWN && dp_lock) begin
						mode_d = pmrc_pkg::PMRC_SLEEP;
					end else begin
						mode_d = i_sleep_mode;
					end
				end
			end
			pmrc_pkg::PMRC_SLEEP: begin
				if (i_wake.irq || gpwake) begin
					mode_d = pmrc_pkg::PMRC_ACTIVE;
				end
			end
			pmrc_pkg::PMRC_DSLEEP: begin
				if (gpwake) begin
					mode_d = pmrc_pkg::PMRC_ACTIVE;
				end
			end
			pmrc_pkg::PMRC_PDOWN: begin
				if (gpwake) begin
					mode_d = pmrc_pkg::PMRC_ACTIVE;
				end
			end
			pmrc_pkg::PMRC_DPDOWN: begin
				if (!wake_lvl_q) begin
					mode_d = pmrc_pkg::PMRC_ACTIVE;
				end
			end
			default: mode_d = pmrc_pkg::PMRC_ACTIVE;
		endcase
	end

	// mode register; reset exits any mode but deep power-down
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			mode_q <= pmrc_pkg::PMRC_ACTIVE;
		end else if (i_clk_en) begin
			if (chip_rst && mode_q != pmrc_pkg::PMRC_DPDOWN) begin
				mode_q <= pmrc_pkg::PMRC_ACTIVE;
			end else begin
				mode_q <= mode_d;
			end
		end
	end

	// ----------------------------------------------------------
	// gates
	// ----------------------------------------------------------
	wire m_act = mode_q == pmrc_pkg::PMRC_ACTIVE;
	wire m_slp = mode_q == pmrc_pkg::PMRC_SLEEP;
	wire m_ds  = mode_q == pmrc_pkg::PMRC_DSLEEP;
	wire m_pd  = mode_q == pmrc_pkg::PMRC_PDOWN;
	wire m_dpd = mode_q == pmrc_pkg::PMRC_DPDOWN;
	wire keep_wdo = ctrl_q[`PMRC_CTRL_WDO_BIT];
	wire keep_bod = ctrl_q[`PMRC_CTRL_BOD_BIT];

	pmrc_pkg::pmrc_gate_t gate_d;
	always_comb begin
		gate_d.core_clk_en   = m_act && !chip_rst;
		gate_d.periph_clk_en = m_act || m_slp;
		gate_d.irc_out_en    = m_act || m_slp || chip_rst ||
		                       (m_ds && ctrl_q[`PMRC_CTRL_WDIRC_BIT]);
		gate_d.wdo_en        = !m_dpd && (!(m_ds || m_pd) || keep_wdo);
		gate_d.bod_en        = !m_dpd && (!(m_ds || m_pd) || keep_bod);
		gate_d.analog_en     = m_act || m_slp;
		gate_d.flash_on      = m_act || m_slp;
		gate_d.flash_stby    = m_ds;
		gate_d.main_pwr      = !m_dpd;
	end

	// ----------------------------------------------------------
	// protection and test port selection
	// ----------------------------------------------------------
	pmrc_pkg::pmrc_crp_t crp_w;
	assign crp_w = (i_crp_word == `PMRC_READ_PROTECT_LEVEL_3_PAT) ? pmrc_pkg::PMRC_CRP_L3 :
	               (i_crp_word == `PMRC_READ_PROTECT_LEVEL_2_PAT) ? pmrc_pkg::PMRC_CRP_L2 :
	               (i_crp_word == `PMRC_READ_PROTECT_LEVEL_1_PAT) ? pmrc_pkg::PMRC_CRP_L1 :
	               pmrc_pkg::PMRC_CRP_NONE;
	pmrc_pkg::pmrc_crp_t crp_q; // latched while reset, fixed afterwards

	pmrc_pkg::pmrc_access_t acc_d;
	always_comb begin
		acc_d.jtag_sel            = !rst_pin_lvl_q;
		acc_d.swd_en              = rst_pin_lvl_q && !chip_rst &&
		                            crp_q == pmrc_pkg::PMRC_CRP_NONE;
		acc_d.isp_allowed         = crp_q != pmrc_pkg::PMRC_CRP_L3;
		acc_d.isp_pin_ok          = crp_q != pmrc_pkg::PMRC_CRP_L3 &&
		                            !ctrl_q[`PMRC_CTRL_ISPD_BIT];
		acc_d.isp_sector0_ok      = crp_q == pmrc_pkg::PMRC_CRP_NONE ||
		                            crp_q == pmrc_pkg::PMRC_CRP_L2;
		acc_d.isp_full_erase_only = crp_q == pmrc_pkg::PMRC_CRP_L2;
		acc_d.iap_allowed         = 1'b1;
	end

	// ----------------------------------------------------------
	// output registers
	// ----------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			crp_q        <= pmrc_pkg::PMRC_CRP_NONE;
			o_gate       <= '0;
			o_access     <= '0;
			o_chip_reset <= 1'b1;
			o_bod_irq    <= 1'b0;
			o_rdata      <= 32'h00000000;
		end else if (i_clk_en) begin
			if (chip_rst) begin
				crp_q <= crp_w;
			end
			o_gate       <= gate_d;
			o_access     <= acc_d;
			o_chip_reset <= chip_rst;
			o_bod_irq    <= bod_flag_q;
			o_rdata      <= 32'h00000000;
			if (i_rd) begin
				unique case (i_addr)
					`PMRC_CTRL_OFS: o_rdata <= {27'h0, ctrl_q};
					`PMRC_STAT_OFS: o_rdata <= {24'h0, crp_q, mode_q, i_bod_irq_lvl,
					                            pin_rst, bod_flag_q};
					`PMRC_BOD_OFS:  o_rdata <= {28'h0, bod_q};
					`PMRC_CRP_OFS:  o_rdata <= {30'h0, crp_q};
					default:        o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign o_mode      = mode_q;
	assign o_crp_level = crp_q;
	assign o_boot_addr = `PMRC_BOOT_ADDR;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	sleep_clk_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && !m_act ##1 i_clk_en |-> !o_gate.core_clk_en)
		else $error("core clock running outside active");
	dpd_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		dp_lock |-> !m_dpd || $past(m_dpd))
		else $error("deep power-down entered while locked");
	sleep_req_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$rose(!m_act) && !$past(chip_rst) |-> $past(i_sleep_req))
		else $error("low power mode without request");
	swd_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && chip_rst ##1 i_clk_en |-> !o_access.swd_en)
		else $error("swd on during reset");
	jtag_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && !rst_pin_lvl_q ##1 i_clk_en |-> o_access.jtag_sel)
		else $error("jtag not selected with reset low");
	read_protect_level_3_isp_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && crp_q == pmrc_pkg::PMRC_CRP_L3 ##1 i_clk_en |-> !o_access.isp_pin_ok && !o_access.isp_allowed)
		else $error("isp allowed at level three");
	bod_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && i_bod_rst_lvl ##1 i_clk_en |-> o_chip_reset)
		else $error("brownout did not reset");
	dpd_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		m_dpd && wake_lvl_q && i_clk_en |=> m_dpd)
		else $error("left deep power-down without wake pin");
	bod_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && i_bod_irq_lvl && !chip_rst |=> bod_flag_q)
		else $error("brownout flag not set");
	rst_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && rst_pin_q[2:1] == 2'b00 |=> chip_rst)
		else $error("reset pin pulse missed");

	// ----------------------------------------------------------
	// gate checks
	// ----------------------------------------------------------
	// the gate outputs are registered, so each check looks one cycle
	// after the mode that should have produced them

	// sleep keeps peripherals clocked so they can raise wake interrupts
	sleep_periph_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_slp ##1 i_clk_en |-> o_gate.periph_clk_en)
		else $error("peripheral clock stopped in sleep");

	// deep-sleep: rc output only when it clocks the watchdog
	ds_irc_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_ds && !chip_rst && !ctrl_q[`PMRC_CTRL_WDIRC_BIT] ##1 i_clk_en
		|-> !o_gate.irc_out_en && !o_gate.periph_clk_en)
		else $error("clock left running in deep-sleep");

	// deep-sleep: analog off, flash parked in standby
	ds_flash_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_ds ##1 i_clk_en |-> o_gate.flash_stby && !o_gate.analog_en)
		else $error("deep-sleep flash or analog state wrong");

	// deep-sleep wakes on gpio, watchdog or usb activity
	ds_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_ds && gpwake |=> m_act)
		else $error("deep-sleep missed a wake source");

	// power-down: peripherals, analog and flash all off
	pd_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_pd ##1 i_clk_en
		|-> !o_gate.periph_clk_en && !o_gate.analog_en && !o_gate.flash_on)
		else $error("power-down left a domain on");

	// power-down wakes on the same sources as deep-sleep
	pd_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_pd && gpwake |=> m_act)
		else $error("power-down missed a wake source");

	// deep power-down drops main power
	dpd_power_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && m_dpd ##1 i_clk_en |-> !o_gate.main_pwr)
		else $error("main power on in deep power-down");

	// any reset source restarts the rc oscillator
	irc_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && chip_rst ##1 i_clk_en |-> o_gate.irc_out_en)
		else $error("rc oscillator off during reset");

	// any protection level closes the debug port
	crp_swd_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_clk_en && crp_q != pmrc_pkg::PMRC_CRP_NONE ##1 i_clk_en |-> !o_access.swd_en)
		else $error("swd open under protection");

endmodule
`default_nettype wire

// ### rtl/pmrc_defs.svh
// constants for the power mode and reset control block
//
// Function
// - sleep gates off the core clock
// - sleep holds execution until reset or interrupt
// - deep-sleep stops clocks except rc oscillator
// - deep-sleep powers analog off, flash standby
// - deep-sleep wakes on reset, gpio, watchdog, usb
// - power-down stops clocks, analog and flash
// - power-down wakes on reset, gpio, watchdog, usb
// - deep power-down wakes only by wake pin
// - lock bit refuses deep power-down entry
// - four reset sources restart oscillator and flash; in deep power-down the flash stays off
// - reset pin pulse of 50 ns counts
// - after reset fetch starts at address zero
// - brownout interrupt level raises interrupt and status
// - brownout reset level forces chip reset
// - flash pattern enables protection, iap always free
// - level one blocks swd, isp except sector0
// - level two blocks swd, isp full erase only
// - level three blocks swd and all isp
// - isp pin entry can be disabled alone
// - reset pin low picks jtag, high swd
// - swd stays disabled during chip reset
`ifndef PMRC_DEFS_SVH
`define PMRC_DEFS_SVH

// register offsets (byte addresses)
`define PMRC_CTRL_OFS      8'h00
`define PMRC_STAT_OFS      8'h04
`define PMRC_BOD_OFS       8'h08
`define PMRC_CRP_OFS       8'h0c

// ctrl field positions
`define PMRC_CTRL_LOCK_BIT 0
`define PMRC_CTRL_WDO_BIT  1
`define PMRC_CTRL_BOD_BIT  2
`define PMRC_CTRL_WDIRC_BIT 3
`define PMRC_CTRL_ISPD_BIT 4

// reset values
`define PMRC_CTRL_RST      5'h04
`define PMRC_BOD_RST       4'h0

// protection patterns found in the dedicated flash word
`define PMRC_READ_PROTECT_LEVEL_1_PAT      32'h12345678
`define PMRC_READ_PROTECT_LEVEL_2_PAT      32'h87654321
`define PMRC_READ_PROTECT_LEVEL_3_PAT      32'h43218765

// reset pin shortest pulse and the clock period at 200 MHz, both in ps
`define PMRC_CLK_PS        5000
`define PMRC_RST_PULSE_PS  50000
`define PMRC_BOOT_ADDR     32'h00000000

`endif

// ### rtl/pmrc_pkg.sv
// types shared by the power mode and reset control block
package pmrc_pkg;
	// low-power modes requested by the core
	typedef enum logic [2:0] {
		PMRC_ACTIVE,
		PMRC_SLEEP,
		PMRC_DSLEEP,
		PMRC_PDOWN,
		PMRC_DPDOWN
	} pmrc_mode_t;
	// protection level decoded from flash
	typedef enum logic [1:0] {
		PMRC_CRP_NONE,
		PMRC_CRP_L1,
		PMRC_CRP_L2,
		PMRC_CRP_L3
	} pmrc_crp_t;
	// wake sources grouped
	typedef struct packed {
		logic gpio;
		logic wdt;
		logic usb;
		logic irq;
	} pmrc_wake_t;
	// clock and power gates driven out
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic irc_out_en;
		logic wdo_en;
		logic bod_en;
		logic analog_en;
		logic flash_on;
		logic flash_stby;
		logic main_pwr;
	} pmrc_gate_t;
	// debug and programming permissions
	typedef struct packed {
		logic swd_en;
		logic jtag_sel;
		logic isp_allowed;
		logic isp_pin_ok;
		logic isp_sector0_ok;
		logic isp_full_erase_only;
		logic iap_allowed;
	} pmrc_access_t;
endpackage

// ### verif/pmrc_pins_model.sv
// pin-side partner: reset and wake pins with their pull-ups
`timescale 1ns/1ps
`default_nettype none

module pmrc_pins_model #(
	parameter int SCAN_WAIT = 20	// settle time before scan, shortened
) (
	input  wire logic i_ref_clk,
	output logic      o_reset_n_pin,
	output logic      o_wake_pin
);
	// ----------------------------------------
	// both pins are pulled up when nobody drives
	// ----------------------------------------
	initial begin
		o_reset_n_pin = 1'b1;
		o_wake_pin    = 1'b1;
	end

	// tester: hold high, settle, pull low for n cycles, release
	task automatic scan_pulse(input int n);
		repeat (SCAN_WAIT) @(posedge i_ref_clk);
		o_reset_n_pin <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
		o_reset_n_pin <= 1'b1;
	endtask

	// wake pin held low for n cycles, then released to its pull-up
	task automatic wake_pulse(input int n);
		@(posedge i_ref_clk);
		o_wake_pin <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
		o_wake_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### verif/power_mode_reset_control_test.sv
// self-checking bench for the power mode and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_defs.svh"

module power_mode_reset_control_test;
	localparam int SW = 20;	// scan settle cycles in the pin model
	logic                   clk, rst, wr, rd, sreq, wrst, por, bi, br, rpin, wpin, crst, birq;
	logic [7:0]             addr;
	logic [31:0]            wdata, code_read_protection, rdata, boot, rv;
	pmrc_pkg::pmrc_mode_t   mreq, mode;
	pmrc_pkg::pmrc_wake_t   wk;
	pmrc_pkg::pmrc_gate_t   gt;
	pmrc_pkg::pmrc_access_t ac;
	pmrc_pkg::pmrc_crp_t    lv;
	int                     errors, checks;
	logic [31:0]            pat [4];

	pmrc_ctrl DUT (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sleep_req(sreq), .i_sleep_mode(mreq), .i_wake(wk),
		.i_reset_n_pin(rpin), .i_wake_pin(wpin), .i_wdt_reset(wrst), .i_por(por), .i_bod_irq_lvl(bi),
		.i_bod_rst_lvl(br), .i_crp_word(code_read_protection), .o_mode(mode), .o_gate(gt), .o_access(ac),
		.o_crp_level(lv), .o_chip_reset(crst), .o_bod_irq(birq), .o_boot_addr(boot));
	pmrc_pins_model #(.SCAN_WAIT(SW)) PINS (.i_ref_clk(clk), .o_reset_n_pin(rpin), .o_wake_pin(wpin));

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// generous bound: the sequence needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait for chip reset to drop before any request
	task automatic settle();
		for (int i = 0; i < 200 && crst !== 1'b0; i++) @(posedge clk);
		@(posedge clk);
		#1 chk("reset release", crst, 1'b0);
	endtask
	task automatic sleep(input pmrc_pkg::pmrc_mode_t m);
		@(posedge clk);
		sreq <= 1'b1; mreq <= m;
		@(posedge clk);
		sreq <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic wait_active();
		for (int i = 0; i < 30 && mode !== pmrc_pkg::PMRC_ACTIVE; i++) @(posedge clk);
		#1 chk("wake mode", mode, pmrc_pkg::PMRC_ACTIVE);
		wk <= '0;
	endtask
	// protection level expected from the flash word
	function automatic pmrc_pkg::pmrc_crp_t lvl_of(input logic [31:0] w);
		if (w == `PMRC_READ_PROTECT_LEVEL_1_PAT) return pmrc_pkg::PMRC_CRP_L1;
		if (w == `PMRC_READ_PROTECT_LEVEL_2_PAT) return pmrc_pkg::PMRC_CRP_L2;
		if (w == `PMRC_READ_PROTECT_LEVEL_3_PAT) return pmrc_pkg::PMRC_CRP_L3;
		return pmrc_pkg::PMRC_CRP_NONE;
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pmrc_pkg::pmrc_crp_t e;
		errors = 0; checks = 0;
		rst = 1'b1; wr = 1'b0; rd = 1'b0; sreq = 1'b0; wrst = 1'b0; por = 1'b0; bi = 1'b0; br = 1'b0;
		addr = 8'h00; wdata = 32'h0; code_read_protection = 32'h0; mreq = pmrc_pkg::PMRC_ACTIVE; wk = '0;
		void'($urandom(32'hf2c7));
		pat = '{`PMRC_READ_PROTECT_LEVEL_1_PAT, `PMRC_READ_PROTECT_LEVEL_2_PAT, `PMRC_READ_PROTECT_LEVEL_3_PAT, $urandom};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk("boot addr", boot, `PMRC_BOOT_ADDR);
		rreg(`PMRC_CTRL_OFS, rv); chk("ctrl reset", rv, 32'(`PMRC_CTRL_RST));
		rreg(8'h3c, rv); chk("unmapped read", rv, 32'h0);
		// a mode selection alone must not enter a low-power state
		mreq <= pmrc_pkg::PMRC_DPDOWN;
		repeat (4) @(posedge clk);
		#1 chk("no request", mode, pmrc_pkg::PMRC_ACTIVE);
		sleep(pmrc_pkg::PMRC_SLEEP);
		chk("sleep mode", mode, pmrc_pkg::PMRC_SLEEP);
		chk("sleep core clk", gt.core_clk_en, 1'b0);
		chk("sleep periph clk", gt.periph_clk_en, 1'b1);
		wk.irq <= 1'b1;
		wait_active();
		repeat (2) @(posedge clk);
		#1 chk("core clk back", gt.core_clk_en, 1'b1);
		// deep-sleep then power-down, each woken by a random source
		for (int k = 0; k < 2; k++) begin
			sleep(k ? pmrc_pkg::PMRC_PDOWN : pmrc_pkg::PMRC_DSLEEP);
			chk("periph off", gt.periph_clk_en, 1'b0);
			chk("irc out off", gt.irc_out_en, 1'b0);
			chk("analog off", gt.analog_en, 1'b0);
			chk("bod kept", gt.bod_en, 1'b1);
			chk("wdo off", gt.wdo_en, 1'b0);
			chk("flash state", k ? gt.flash_on : gt.flash_stby, k ? 1'b0 : 1'b1);
			wk.irq <= 1'b1;
			repeat (4) @(posedge clk);
			#1 chk("irq no wake", mode, k ? pmrc_pkg::PMRC_PDOWN : pmrc_pkg::PMRC_DSLEEP);
			wk <= pmrc_pkg::pmrc_wake_t'(4'h8 >> $urandom_range(2, 0));
			wait_active();
		end
		// locked deep power-down falls back to sleep
		wreg(`PMRC_CTRL_OFS, 32'h5);
		sleep(pmrc_pkg::PMRC_DPDOWN);
		chk("locked dpd", mode, pmrc_pkg::PMRC_SLEEP);
		wk.irq <= 1'b1;
		wait_active();
		wreg(`PMRC_CTRL_OFS, 32'h4);
		sleep(pmrc_pkg::PMRC_DPDOWN);
		chk("dpd power", gt.main_pwr, 1'b0);
		wk.gpio <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk("dpd gpio ignored", mode, pmrc_pkg::PMRC_DPDOWN);
		wk <= '0;
		PINS.wake_pulse(10);
		wait_active();
		// brownout interrupt level, then reset level
		bi <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("bod irq", birq, 1'b1);
		rreg(`PMRC_STAT_OFS, rv); chk("bod status", rv[0], 1'b1);
		bi <= 1'b0;
		wreg(`PMRC_STAT_OFS, 32'h1);
		repeat (2) @(posedge clk);
		#1 chk("bod irq clear", birq, 1'b0);
		br <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("bod reset", crst, 1'b1);
		br <= 1'b0;
		settle();
		// reset pin low: boundary scan selected, debug port off
		fork
			PINS.scan_pulse(10);
			begin
				repeat (SW + 8) @(posedge clk);
				#1 chk("pin reset", crst, 1'b1);
				chk("swd in reset", ac.swd_en, 1'b0);
				chk("jtag select", ac.jtag_sel, 1'b1);
			end
		join
		settle();
		chk("swd select", ac.swd_en, 1'b1);
		chk("jtag deselect", ac.jtag_sel, 1'b0);
		// every protection level, entered by alternating reset sources
		for (int k = 0; k < 4; k++) begin
			e = lvl_of(pat[k]);
			code_read_protection <= pat[k];
			if (k[0]) wrst <= 1'b1;
			else por <= 1'b1;
			repeat (2) @(posedge clk);
			wrst <= 1'b0; por <= 1'b0;
			settle();
			chk("crp level", lv, e);
			chk("iap", ac.iap_allowed, 1'b1);
			chk("swd", ac.swd_en, e == pmrc_pkg::PMRC_CRP_NONE);
			chk("isp", ac.isp_allowed, e != pmrc_pkg::PMRC_CRP_L3);
			chk("isp pin", ac.isp_pin_ok, e != pmrc_pkg::PMRC_CRP_L3);
			chk("full erase", ac.isp_full_erase_only, e == pmrc_pkg::PMRC_CRP_L2);
			chk("sector0", ac.isp_sector0_ok, e == pmrc_pkg::PMRC_CRP_NONE || e == pmrc_pkg::PMRC_CRP_L2);
		end
		// pin entry disabled while no protection level is active
		wreg(`PMRC_CTRL_OFS, 32'h14);
		repeat (3) @(posedge clk);
		#1 chk("isp pin off", ac.isp_pin_ok, 1'b0);
		chk("isp still on", ac.isp_allowed, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
